/* File: rtl/itrb_pkg.sv */
// Register map, field layouts and reset values of the tuning register bank
`default_nettype none
package itrb_pkg;

  localparam int ITRB_NREG = 49;

  // Address, writable-bit mask and reset value of each read/write register
  localparam logic [15:0] ITRB_ADDR [ITRB_NREG] = '{
    16'h03B3, 16'h03B4, 16'h03B5, 16'h03B6, 16'h03B7, 16'h03B8, 16'h03B9, 16'h03BA,
    16'h03BB, 16'h03BC, 16'h03E0, 16'h03E1, 16'h03E4, 16'h03E5, 16'h03E8, 16'h03E9,
    16'h03EC, 16'h03ED, 16'h0458, 16'h0459, 16'h045A, 16'h045B, 16'h045C, 16'h045D,
    16'h0478, 16'h0486, 16'h0487, 16'h0488, 16'h04B0, 16'h04B3, 16'h04B6, 16'h04B9,
    16'h04BC, 16'h04BE, 16'h04C2, 16'h04C3, 16'h0540, 16'h0541, 16'h0542, 16'h0543,
    16'h0544, 16'h0545, 16'h0546, 16'h0547, 16'h0548, 16'h0549, 16'h054C, 16'h0380,
    16'h0580};
  localparam logic [7:0] ITRB_MASK [ITRB_NREG] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'h77, 8'h77, 8'h77, 8'h77, 8'h77, 8'h77,
    8'h77, 8'h77, 8'hFF, 8'h0F, 8'h03, 8'hFF, 8'h03, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'h7F, 8'h7F, 8'h7F,
    8'h1F, 8'h1F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'h1F, 8'h03,
    8'h0F};
  localparam logic [7:0] ITRB_RESET [ITRB_NREG] = '{
    8'h10, 8'h00, 8'h10, 8'h00, 8'h70, 8'h00, 8'h90, 8'h00,
    8'hFF, 8'hFF, 8'h10, 8'h01, 8'h21, 8'h12, 8'h32, 8'h23,
    8'h21, 8'h12, 8'h80, 8'h03, 8'h00, 8'h50, 8'h00, 8'h90,
    8'h00, 8'h00, 8'hFF, 8'h30, 8'h50, 8'h00, 8'h30, 8'h10,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h8D, 8'h00, 8'hA9,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03,
    8'h04};

  // Index of each register within the tables above
  localparam int IX_ORG_ROW_LO  = 0;
  localparam int IX_ORG_COL_LO  = 2;
  localparam int IX_STEP_ROW_LO = 4;
  localparam int IX_STEP_COL_LO = 6;
  localparam int IX_WIN_EN_LO   = 8;
  localparam int IX_WEIGHT_BASE = 10;
  localparam int IX_OD_UPPER    = 18;
  localparam int IX_OD_LOWER    = 19;
  localparam int IX_CT_NORM_HI  = 20;
  localparam int IX_CT_INC_HI   = 22;
  localparam int IX_GAIN_OVR    = 24;
  localparam int IX_HUE_SINE    = 25;
  localparam int IX_HUE_COSINE  = 26;
  localparam int IX_SCENE       = 27;
  localparam int IX_CON_MID     = 28;
  localparam int IX_CON_CENTER  = 29;
  localparam int IX_CON_END     = 30;
  localparam int IX_CON_OFFSET  = 31;
  localparam int IX_CON_GAIN    = 32;
  localparam int IX_CON_GAIN_A  = 33;
  localparam int IX_LUMA_CTRL   = 34;
  localparam int IX_FIXED_LUMA  = 35;
  localparam int IX_FLK_SIXTY   = 36;
  localparam int IX_FLK_FIFTY   = 38;
  localparam int IX_CAP_SIXTY   = 40;
  localparam int IX_CAP_FIFTY   = 42;
  localparam int IX_FRAC_SIXTY  = 44;
  localparam int IX_FRAC_FIFTY  = 45;
  localparam int IX_SUBROW      = 46;
  localparam int IX_ENABLES     = 47;
  localparam int IX_DENOISE     = 48;

  // Read-only live value addresses
  localparam logic [15:0] ADDR_LIVE_BLEND   = 16'h0470;
  localparam logic [15:0] ADDR_LIVE_OUTDOOR = 16'h0471;
  localparam logic [15:0] ADDR_LIVE_TEMP    = 16'h0472;
  localparam logic [15:0] ADDR_LIVE_GAIN    = 16'h0479;

  // Field positions
  localparam int SCENE_EN_BIT   = 0;
  localparam int SCENE_XOR_BIT  = 1;
  localparam int SCENE_LIM_LSB  = 4;
  localparam int LUMA_P2I_BIT   = 3;
  localparam int LUMA_CCM_BIT   = 4;
  localparam int LUMA_SYNC_LSB  = 5;
  localparam int ENA_AE_BIT     = 0;
  localparam int ENA_AWB_BIT    = 1;

  localparam logic [4:0] ITRB_GAIN_MIN = 5'h01;

  typedef enum logic [2:0] {
    ITRB_FX_NONE   = 3'b000,
    ITRB_FX_EMBOSS = 3'b001,
    ITRB_FX_SKETCH = 3'b010,
    ITRB_FX_SOLMID = 3'b011,
    ITRB_FX_SOLALL = 3'b100,
    ITRB_FX_LUMA   = 3'b101
  } itrb_effect_t;

  typedef enum logic [1:0] {
    ITRB_LIM_OFF  = 2'b00,
    ITRB_LIM_ALL  = 2'b01,
    ITRB_LIM_NORB = 2'b10,
    ITRB_LIM_MAX  = 2'b11
  } itrb_limit_t;

  typedef enum logic [1:0] {
    ITRB_SR_NORMAL = 2'b00,
    ITRB_SR_SWITCH = 2'b01,
    ITRB_SR_FULL   = 2'b10
  } itrb_subrow_t;

endpackage : itrb_pkg
`default_nettype wire

/* File: rtl/itrb_reg8.sv */
// One 8-bit read/write tuning register with a writable-bit mask
`timescale 1ns/1ps
`default_nettype none
module itrb_reg8 #(
  parameter logic [7:0] MASK  = 8'hFF,
  parameter logic [7:0] RESET = 8'h00
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Stored value
  output logic      [7:0] q_ff
);

  // Unused bits stay zero whatever is written
  always_ff @(posedge clock) begin
    if (rst) begin
      q_ff <= RESET & MASK;
    end else if (wr_en) begin
      q_ff <= wr_data & MASK;
    end
  end

endmodule : itrb_reg8
`default_nettype wire

/* File: rtl/itrb_top.sv */
// Tuning register bank of the image pipeline with decoded control outputs
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module itrb_top
  import itrb_pkg::*;
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Register port
  input  wire logic [15:0]  reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [7:0]   reg_rdata,
  // Live values from the pixel pipeline
  input  wire logic [7:0]   live_blend_in,
  input  wire logic [7:0]   live_outdoor_in,
  input  wire logic [7:0]   live_temp_in,
  input  wire logic [7:0]   auto_gain_blend_in,
  input  wire logic         ct_sign_normal,
  input  wire logic         ct_sign_incandescent,
  input  wire logic         hue_enable,
  input  wire logic         capture_mode,
  // Statistics grid
  output logic      [15:0]  grid_origin_row,
  output logic      [15:0]  grid_origin_col,
  output logic      [15:0]  grid_step_row,
  output logic      [15:0]  grid_step_col,
  output logic      [63:0]  grid_cell_weight,
  // Blending
  output logic      [7:0]   outdoor_upper_coef,
  output logic      [7:0]   outdoor_lower_coef,
  output logic      [10:0]  normal_temp_threshold,
  output logic      [10:0]  incandescent_threshold,
  output logic      [7:0]   gain_blend_used,
  // Hue and scene
  output logic              scene_chroma_fixed,
  output logic      [7:0]   fixed_cb_value,
  output logic      [7:0]   fixed_cr_value,
  output logic      [1:0]   gain_limit_mode,
  output logic              invert_enable,
  output logic              scene_enable,
  // Contrast
  output logic      [7:0]   contrast_mid_slope_out,
  output logic      [6:0]   contrast_center_out,
  output logic      [6:0]   contrast_end_slope_out,
  output logic      [6:0]   contrast_offset_out,
  output logic      [4:0]   contrast_gain_out,
  output logic      [4:0]   contrast_gain_blend_out,
  // Luma path
  output logic      [1:0]   frame_sync_edges,
  output logic              luma_matrix_enable,
  output logic              progressive_to_interlace,
  output logic      [2:0]   special_effect,
  output logic              luma_override_valid,
  output logic      [7:0]   luma_override_value,
  output logic      [3:0]   luma_denoise_strength,
  // Exposure
  output logic      [19:0]  flicker_step_sixty,
  output logic      [19:0]  flicker_step_fifty,
  output logic      [1:0]   partial_row_integration,
  output logic      [2:0]   subrow_options,
  output logic              exposure_enable,
  output logic              balance_enable
);

  logic [7:0]            q [ITRB_NREG];
  logic [ITRB_NREG-1:0]  hit;
  logic [7:0]            live_blend_ff;
  logic [7:0]            live_outdoor_ff;
  logic [7:0]            live_temp_ff;
  logic [7:0]            live_gain_ff;
  logic [7:0]            nxt_rdata;
  logic [7:0]            nxt_gain_used;
  logic [7:0]            nxt_lower;
  logic [15:0]           win_en;
  logic [7:0]            od_off;

  // One masked register per table entry
  genvar gi;
  generate
    for (gi = 0; gi < ITRB_NREG; gi++) begin : g_reg
      assign hit[gi] = (reg_addr == ITRB_ADDR[gi]);
      itrb_reg8 #(
        .MASK  (ITRB_MASK[gi]),
        .RESET (ITRB_RESET[gi])
      ) u_reg (
        .clock   (clock),
        .rst     (rst),
        .wr_en   (reg_wr && hit[gi]),
        .wr_data (reg_wdata),
        .q_ff    (q[gi])
      );
    end
  endgenerate

  // Live values are sampled every cycle; the bus cannot touch them
  always_ff @(posedge clock) begin
    if (rst) begin
      live_blend_ff   <= 8'h00;
      live_outdoor_ff <= 8'h00;
      live_temp_ff    <= 8'h00;
      live_gain_ff    <= 8'h00;
    end else begin
      live_blend_ff   <= live_blend_in;
      live_outdoor_ff <= live_outdoor_in;
      live_temp_ff    <= live_temp_in;
      live_gain_ff    <= nxt_gain_used;
    end
  end

  // Manual override wins whenever nonzero
  assign nxt_gain_used = (q[IX_GAIN_OVR] != 8'h00) ? q[IX_GAIN_OVR]
                                                   : auto_gain_blend_in;

  // Read mux; unmapped addresses answer zero
  always_comb begin
    nxt_rdata = 8'h00;
    for (int i = 0; i < ITRB_NREG; i++) begin
      if (hit[i]) begin
        nxt_rdata = q[i];
      end
    end
    case (reg_addr)
      ADDR_LIVE_BLEND:   nxt_rdata = live_blend_ff;
      ADDR_LIVE_OUTDOOR: nxt_rdata = live_outdoor_ff;
      ADDR_LIVE_TEMP:    nxt_rdata = live_temp_ff;
      ADDR_LIVE_GAIN:    nxt_rdata = live_gain_ff;
      default:           nxt_rdata = nxt_rdata;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Window enables, first window of row one at bit 0
  assign win_en = {q[IX_WIN_EN_LO+1], q[IX_WIN_EN_LO]};

  // Weight code to eighths; undefined codes give no weight
  function automatic logic [3:0] weight_eighths(input logic [2:0] code);
    case (code)
      3'h4:    weight_eighths = 4'h1;
      3'h0:    weight_eighths = 4'h2;
      3'h1:    weight_eighths = 4'h4;
      3'h2:    weight_eighths = 4'h6;
      3'h3:    weight_eighths = 4'h8;
      default: weight_eighths = 4'h0;
    endcase
  endfunction : weight_eighths

  // Per-cell effective weight, zero when the window is disabled
  generate
    for (gi = 0; gi < 16; gi++) begin : g_cell
      logic [7:0] wbyte;
      logic [2:0] wcode;
      assign wbyte = q[IX_WEIGHT_BASE + 2*(gi/4) + (gi%4)/2];
      assign wcode = ((gi % 2) == 0) ? wbyte[2:0] : wbyte[6:4];
      always_ff @(posedge clock) begin
        if (rst) begin
          grid_cell_weight[4*gi +: 4] <= 4'h0;
        end else begin
          grid_cell_weight[4*gi +: 4] <= win_en[gi] ? weight_eighths(wcode)
                                                    : 4'h0;
        end
      end
    end
  endgenerate

  // Grid geometry
  always_ff @(posedge clock) begin
    if (rst) begin
      grid_origin_row <= 16'h0000;
      grid_origin_col <= 16'h0000;
      grid_step_row   <= 16'h0000;
      grid_step_col   <= 16'h0000;
    end else begin
      grid_origin_row <= {q[IX_ORG_ROW_LO+1], q[IX_ORG_ROW_LO]};
      grid_origin_col <= {q[IX_ORG_COL_LO+1], q[IX_ORG_COL_LO]};
      grid_step_row   <= {q[IX_STEP_ROW_LO+1], q[IX_STEP_ROW_LO]};
      grid_step_col   <= {q[IX_STEP_COL_LO+1], q[IX_STEP_COL_LO]};
    end
  end

  // Outdoor offset decode; codes above five subtract nothing
  always_comb begin
    case (q[IX_OD_LOWER][3:0])
      4'h1:    od_off = 8'h08;
      4'h2:    od_off = 8'h10;
      4'h3:    od_off = 8'h20;
      4'h4:    od_off = 8'h40;
      4'h5:    od_off = 8'h80;
      default: od_off = 8'h00;
    endcase
  end

  // Clamp at zero so a small upper value cannot wrap
  assign nxt_lower = (q[IX_OD_UPPER] > od_off) ? 8'(q[IX_OD_UPPER] - od_off) : 8'h00;

  // Blending coefficients and thresholds
  always_ff @(posedge clock) begin
    if (rst) begin
      outdoor_upper_coef     <= 8'h00;
      outdoor_lower_coef     <= 8'h00;
      normal_temp_threshold  <= 11'h000;
      incandescent_threshold <= 11'h000;
      gain_blend_used        <= 8'h00;
    end else begin
      outdoor_upper_coef     <= q[IX_OD_UPPER];
      outdoor_lower_coef     <= nxt_lower;
      normal_temp_threshold  <= {ct_sign_normal, q[IX_CT_NORM_HI][1:0],
                                 q[IX_CT_NORM_HI+1]};
      incandescent_threshold <= {ct_sign_incandescent, q[IX_CT_INC_HI][1:0],
                                 q[IX_CT_INC_HI+1]};
      gain_blend_used        <= nxt_gain_used;
    end
  end

  // Hue registers double as fixed chroma in scene mode
  always_ff @(posedge clock) begin
    if (rst) begin
      scene_chroma_fixed <= 1'b0;
      fixed_cb_value     <= 8'h00;
      fixed_cr_value     <= 8'h00;
      gain_limit_mode    <= ITRB_LIM_OFF;
      invert_enable      <= 1'b0;
      scene_enable       <= 1'b0;
    end else begin
      scene_chroma_fixed <= q[IX_SCENE][SCENE_EN_BIT] && !hue_enable;
      fixed_cb_value     <= q[IX_HUE_SINE];
      fixed_cr_value     <= q[IX_HUE_COSINE];
      gain_limit_mode    <= q[IX_SCENE][SCENE_LIM_LSB +: 2];
      invert_enable      <= q[IX_SCENE][SCENE_XOR_BIT];
      scene_enable       <= q[IX_SCENE][SCENE_EN_BIT];
    end
  end

  // Contrast curve; gains below one are raised to one
  always_ff @(posedge clock) begin
    if (rst) begin
      contrast_mid_slope_out  <= 8'h00;
      contrast_center_out     <= 7'h00;
      contrast_end_slope_out  <= 7'h00;
      contrast_offset_out     <= 7'h00;
      contrast_gain_out       <= ITRB_GAIN_MIN;
      contrast_gain_blend_out <= ITRB_GAIN_MIN;
    end else begin
      contrast_mid_slope_out  <= q[IX_CON_MID];
      contrast_center_out     <= q[IX_CON_CENTER][6:0];
      contrast_end_slope_out  <= q[IX_CON_END][6:0];
      contrast_offset_out     <= q[IX_CON_OFFSET][6:0];
      contrast_gain_out       <= (q[IX_CON_GAIN][4:0] < ITRB_GAIN_MIN) ? ITRB_GAIN_MIN
                                 : q[IX_CON_GAIN][4:0];
      contrast_gain_blend_out <= (q[IX_CON_GAIN_A][4:0] < ITRB_GAIN_MIN) ? ITRB_GAIN_MIN
                                 : q[IX_CON_GAIN_A][4:0];
    end
  end

  // Luma path controls and special effects
  always_ff @(posedge clock) begin
    if (rst) begin
      frame_sync_edges         <= 2'h0;
      luma_matrix_enable       <= 1'b0;
      progressive_to_interlace <= 1'b0;
      special_effect           <= ITRB_FX_NONE;
      luma_override_valid      <= 1'b0;
      luma_override_value      <= 8'h00;
      luma_denoise_strength    <= 4'h0;
    end else begin
      frame_sync_edges         <= q[IX_LUMA_CTRL][LUMA_SYNC_LSB +: 2];
      luma_matrix_enable       <= q[IX_LUMA_CTRL][LUMA_CCM_BIT];
      progressive_to_interlace <= q[IX_LUMA_CTRL][LUMA_P2I_BIT];
      special_effect           <= q[IX_LUMA_CTRL][2:0];
      luma_override_valid      <= (q[IX_LUMA_CTRL][2:0] == ITRB_FX_LUMA);
      luma_override_value      <= (q[IX_LUMA_CTRL][2:0] == ITRB_FX_LUMA)
                                  ? q[IX_FIXED_LUMA] : 8'h00;
      luma_denoise_strength    <= q[IX_DENOISE][3:0];
    end
  end

  // Flicker steps; capture steps carry no fraction
  always_ff @(posedge clock) begin
    if (rst) begin
      flicker_step_sixty <= 20'h00000;
      flicker_step_fifty <= 20'h00000;
    end else if (capture_mode) begin
      flicker_step_sixty <= {q[IX_CAP_SIXTY], q[IX_CAP_SIXTY+1], 4'h0};
      flicker_step_fifty <= {q[IX_CAP_FIFTY], q[IX_CAP_FIFTY+1], 4'h0};
    end else begin
      flicker_step_sixty <= {q[IX_FLK_SIXTY], q[IX_FLK_SIXTY+1],
                             q[IX_FRAC_SIXTY][3:0]};
      flicker_step_fifty <= {q[IX_FLK_FIFTY], q[IX_FLK_FIFTY+1],
                             q[IX_FRAC_FIFTY][3:0]};
    end
  end

  // Sub-row mode and loop enables; reserved mode 11 falls back to normal
  always_ff @(posedge clock) begin
    if (rst) begin
      partial_row_integration <= ITRB_SR_NORMAL;
      subrow_options          <= 3'h0;
      exposure_enable         <= 1'b0;
      balance_enable          <= 1'b0;
    end else begin
      case (q[IX_SUBROW][1:0])
        ITRB_SR_SWITCH: partial_row_integration <= ITRB_SR_SWITCH;
        ITRB_SR_FULL:   partial_row_integration <= ITRB_SR_FULL;
        default:        partial_row_integration <= ITRB_SR_NORMAL;
      endcase
      subrow_options  <= q[IX_SUBROW][4:2];
      exposure_enable <= q[IX_ENABLES][ENA_AE_BIT];
      balance_enable  <= q[IX_ENABLES][ENA_AWB_BIT];
    end
  end

endmodule : itrb_top
`default_nettype wire

/* File: test/itrb_top_asserts.sv */
// Port-level checker for the tuning register bank
`timescale 1ns/1ps
`default_nettype none
module itrb_asserts
  import itrb_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Pipeline inputs
  input wire logic [7:0]  live_blend_in,
  input wire logic [7:0]  auto_gain_blend_in,
  input wire logic        hue_enable,
  input wire logic        capture_mode,
  // Decoded outputs
  input wire logic [7:0]  outdoor_upper_coef,
  input wire logic [7:0]  outdoor_lower_coef,
  input wire logic [7:0]  gain_blend_used,
  input wire logic        scene_chroma_fixed,
  input wire logic        scene_enable,
  input wire logic [4:0]  contrast_gain_out,
  input wire logic [2:0]  special_effect,
  input wire logic        luma_override_valid,
  input wire logic [19:0] flicker_step_sixty,
  input wire logic [1:0]  partial_row_integration
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Override write, then a quiet cycle so the value is not replaced
  sequence s_ovr_wr;
    reg_wr && reg_addr == 16'h0478;
  endsequence
  sequence s_ovr_quiet;
    !(reg_wr && reg_addr == 16'h0478);
  endsequence

  property p_gain_manual;
    s_ovr_wr ##0 (reg_wdata != 8'h00) ##1 s_ovr_quiet |=> gain_blend_used == $past(reg_wdata, 2);
  endproperty
  a_gain_manual: assert property (p_gain_manual) else $error("manual blend not used");
  property p_gain_auto;
    s_ovr_wr ##0 (reg_wdata == 8'h00) ##1 s_ovr_quiet |=> gain_blend_used == $past(auto_gain_blend_in);
  endproperty
  a_gain_auto: assert property (p_gain_auto) else $error("auto blend not used");
  property p_unused_zero;
    reg_rd && reg_addr == 16'h0488 |=> (reg_rdata & 8'hCC) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero");
  // Live value passes a sampling stage and the read stage
  property p_live_read;
    reg_rd && reg_addr == 16'h0470 |=> reg_rdata == $past(live_blend_in, 2);
  endproperty
  a_live_read: assert property (p_live_read) else $error("live blend readback wrong");
  property p_lower_coef;
    outdoor_lower_coef <= outdoor_upper_coef;
  endproperty
  a_lower_coef: assert property (p_lower_coef) else $error("lower coef above upper");
  property p_contrast_min;
    contrast_gain_out >= ITRB_GAIN_MIN;
  endproperty
  a_contrast_min: assert property (p_contrast_min) else $error("contrast gain below one");
  property p_capture_frac;
    $past(capture_mode) |-> flicker_step_sixty[3:0] == 4'h0;
  endproperty
  a_capture_frac: assert property (p_capture_frac) else $error("capture step has fraction");
  property p_subrow_legal;
    partial_row_integration != 2'b11;
  endproperty
  a_subrow_legal: assert property (p_subrow_legal) else $error("reserved sub-row mode");
  property p_luma_valid;
    luma_override_valid == (special_effect == 3'h5);
  endproperty
  a_luma_valid: assert property (p_luma_valid) else $error("fixed luma flag wrong");
  property p_scene_fixed;
    scene_chroma_fixed == (scene_enable && !$past(hue_enable));
  endproperty
  a_scene_fixed: assert property (p_scene_fixed) else $error("scene chroma flag wrong");
endmodule : itrb_asserts

bind itrb_top itrb_asserts u_itrb_asserts (.*);
`default_nettype wire

/* File: test/test_isp_tuning_register_bank.sv */
// Self-checking testbench for the tuning register bank
`timescale 1ns/1ps
`default_nettype none
module test_isp_tuning_register_bank
  import itrb_pkg::*;
;
  logic        clock, rst, reg_wr, reg_rd, ct_sign_normal, ct_sign_incandescent;
  logic        hue_enable, capture_mode;
  logic [15:0] reg_addr, grid_origin_row, grid_origin_col, grid_step_row, grid_step_col;
  logic [7:0]  reg_wdata, reg_rdata, live_blend_in, live_outdoor_in, live_temp_in;
  logic [7:0]  auto_gain_blend_in, outdoor_upper_coef, outdoor_lower_coef, gain_blend_used;
  logic [63:0] grid_cell_weight;
  logic [10:0] normal_temp_threshold, incandescent_threshold;
  logic        scene_chroma_fixed, invert_enable, scene_enable, luma_matrix_enable;
  logic        progressive_to_interlace, luma_override_valid, exposure_enable, balance_enable;
  logic [7:0]  fixed_cb_value, fixed_cr_value, contrast_mid_slope_out, luma_override_value;
  logic [1:0]  gain_limit_mode, frame_sync_edges, partial_row_integration;
  logic [6:0]  contrast_center_out, contrast_end_slope_out, contrast_offset_out;
  logic [4:0]  contrast_gain_out, contrast_gain_blend_out;
  logic [2:0]  special_effect, subrow_options;
  logic [3:0]  luma_denoise_strength;
  logic [19:0] flicker_step_sixty, flicker_step_fifty;
  int          fail_count, samples_checked;

  itrb_top u_itrb_top (.*);

  // Free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Write, then wait until the decoded outputs have followed
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
    #1;
  endtask : wr

  // Read data is only valid in the cycle after the strobe
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rc

  task automatic t_map;
    for (int i = 0; i < ITRB_NREG; i++) begin
      rc(ITRB_ADDR[i], ITRB_RESET[i] & ITRB_MASK[i]);
      wr(ITRB_ADDR[i], 8'hFF);
      rc(ITRB_ADDR[i], ITRB_MASK[i]);
      wr(ITRB_ADDR[i], ITRB_RESET[i]);
    end
    wr(16'h0400, 8'h5A);
    rc(16'h0400, 8'h00);
    wr(16'h03B3, 8'h34);
    wr(16'h03B4, 8'h12);
    wr(16'h03B9, 8'hCD);
    wr(16'h03BA, 8'hAB);
    chk({grid_origin_row, grid_origin_col}, 32'h1234_0010);
    chk({grid_step_row, grid_step_col}, 32'h0070_ABCD);
    $display("map done");
  endtask : t_map

  task automatic t_grid;
    logic [3:0] w [5] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8};
    logic [2:0] c [5] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h3};
    logic [7:0] off [6] = '{8'h00, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
    for (int i = 0; i < 5; i++) begin
      wr(16'h03E0, {1'b0, c[i], 1'b0, c[(i + 1) % 5]});
      chk(grid_cell_weight[7:0], {w[i], w[(i + 1) % 5]});
    end
    wr(16'h03BB, 8'hFE);
    chk(grid_cell_weight[7:0], 8'h80);
    wr(16'h03BB, 8'hFF);
    wr(16'h0458, 8'hA0);
    for (int i = 0; i < 6; i++) begin
      wr(16'h0459, 8'(i));
      chk({outdoor_upper_coef, outdoor_lower_coef}, {8'hA0, 8'hA0 - off[i]});
    end
    @(posedge clock);
    ct_sign_normal <= 1'b1;
    wr(16'h045A, 8'hFF);
    wr(16'h045B, 8'h5A);
    wr(16'h045C, 8'h02);
    wr(16'h045D, 8'hC3);
    chk({normal_temp_threshold, incandescent_threshold}, {11'h75A, 11'h2C3});
    $display("grid done");
  endtask : t_grid

  task automatic t_live;
    @(posedge clock);
    live_blend_in      <= 8'h11;
    live_outdoor_in    <= 8'h22;
    live_temp_in       <= 8'h33;
    auto_gain_blend_in <= 8'h44;
    wr(16'h0470, 8'hEE);
    rc(16'h0470, 8'h11);
    rc(16'h0471, 8'h22);
    rc(16'h0472, 8'h33);
    rc(16'h0479, 8'h44);
    wr(16'h0478, 8'h5C);
    rc(16'h0479, 8'h5C);
    wr(16'h0478, 8'h00);
    chk(gain_blend_used, 8'h44);
    $display("live done");
  endtask : t_live

  task automatic t_scene;
    wr(16'h0486, 8'h6B);
    wr(16'h0487, 8'h9D);
    for (int m = 0; m < 4; m++) begin
      wr(16'h0488, {2'b00, 2'(m), 4'h3});
      chk({gain_limit_mode, invert_enable, scene_enable}, {2'(m), 2'b11});
    end
    chk({scene_chroma_fixed, fixed_cb_value, fixed_cr_value}, 17'h16B9D);
    @(posedge clock);
    hue_enable <= 1'b1;
    wr(16'h0488, 8'h01);
    chk({scene_chroma_fixed, invert_enable, scene_enable}, 3'b001);
    $display("scene done");
  endtask : t_scene

  task automatic t_luma;
    wr(16'h04C3, 8'hA7);
    for (int s = 0; s < 6; s++) begin
      wr(16'h04C2, {1'b0, s[1:0], s[0], ~s[0], s[2:0]});
      chk({frame_sync_edges, luma_matrix_enable, progressive_to_interlace, special_effect},
          {s[1:0], s[0], ~s[0], s[2:0]});
      chk({luma_override_valid, luma_override_value}, (s == 5) ? 9'h1A7 : 9'h000);
    end
    $display("luma done");
  endtask : t_luma

  task automatic t_expo;
    logic [7:0] v [10] = '{8'h12, 8'h34, 8'h9A, 8'hBC, 8'h56, 8'h78, 8'hDE, 8'hF0, 8'hFA, 8'h05};
    for (int i = 0; i < 10; i++) wr(16'(16'h0540 + i), v[i]);
    chk({flicker_step_sixty, flicker_step_fifty}, 40'h1234A_9ABC5);
    @(posedge clock);
    capture_mode <= 1'b1;
    wr(16'h04BE, 8'h13);
    chk({flicker_step_sixty, flicker_step_fifty}, 40'h56780_DEF00);
    chk({contrast_gain_out, contrast_gain_blend_out}, 10'h033);
    for (int m = 0; m < 4; m++) begin
      wr(16'h054C, 8'(m * 5));
      chk(partial_row_integration, (m == 3) ? 2'b00 : 2'(m));
      chk(subrow_options, 3'(m));
    end
    chk({contrast_mid_slope_out, contrast_end_slope_out}, 15'h2830);
    wr(16'h0580, 8'hFF);
    chk(luma_denoise_strength, 4'hF);
    wr(16'h04B3, 8'hFF);
    wr(16'h04B9, 8'h40);
    chk({contrast_center_out, contrast_offset_out}, 14'h3FC0);
    wr(16'h0380, 8'h02);
    chk({balance_enable, exposure_enable}, 2'b10);
    $display("exposure done");
  endtask : t_expo

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Main sequence, inputs idle from time zero
  initial begin
    {rst, reg_wr, reg_rd, ct_sign_normal, ct_sign_incandescent} = 5'h10;
    {hue_enable, capture_mode, reg_addr, reg_wdata} = '0;
    {live_blend_in, live_outdoor_in, live_temp_in, auto_gain_blend_in} = '0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_map;
    t_grid;
    t_live;
    t_scene;
    t_luma;
    t_expo;
    end_of_test;
  end

  // Watchdog well beyond the roughly 700 cycles the tests need
  initial begin
    #100000;
    fail_count++;
    end_of_test;
  end
endmodule : test_isp_tuning_register_bank
`default_nettype wire
